// File: rtl/ipra_regs.svh
// Offsets, field positions, codes and timing counts of the paged I2C control port
`ifndef IPRA_REGS_SVH
`define IPRA_REGS_SVH
`define IPRA_ADDR_MAIN   7'h4E
`define IPRA_ADDR_BCAST  7'h4C
`define IPRA_REG_PAGE    7'h00
`define IPRA_REG_SWRST   7'h01
`define IPRA_REG_SLEEP   7'h02
`define IPRA_BIT_SWRST   0
`define IPRA_BIT_BCAST   2
`define IPRA_PAGE_DEF    8'h00
`define IPRA_PAGE_CFG    8'h00
`define IPRA_COEF_FIRST  8'h02
`define IPRA_COEF_LAST   8'h04
`define IPRA_BANK_OFS    8'h01
`define IPRA_MEM_DEF     8'h00
`define IPRA_BYTE_BITS   4'h8
`define IPRA_LAST_BIT    4'h7
`define IPRA_SYNC_IDLE   3'h7
`define IPRA_APB_CTRL    12'h000
`define IPRA_APB_STAT    12'h004
`define IPRA_APB_DIV     12'h008
`define IPRA_F_OP        2:0
`define IPRA_F_DATA      15:8
`define IPRA_F_BUSY      0
`define IPRA_F_NACK      1
`define IPRA_F_DIV       15:0
`define IPRA_OP_START    3'h1
`define IPRA_OP_STOP     3'h2
`define IPRA_OP_WRITE    3'h3
`define IPRA_OP_RD_ACK   3'h4
`define IPRA_OP_RD_NACK  3'h5
`define IPRA_DIV_RST     16'h000D
`define IPRA_DIV_MIN     16'h0004
`define IPRA_PH_DRIVE    2'h0
`define IPRA_PH_RISE     2'h1
`define IPRA_PH_SAMPLE   2'h2
`define IPRA_PH_FALL     2'h3
`endif

// File: rtl/ipra_pkg.sv
// State types shared by both ends of the paged I2C control port
package ipra_pkg;
    typedef enum logic [2:0] {DS_IDLE, DS_RX, DS_ACK, DS_TX, DS_MACK} ipra_dstate_t;
    typedef enum logic [1:0] {BY_ADDR, BY_REG, BY_DATA} ipra_byte_t;
    typedef enum logic [1:0] {HS_IDLE, HS_START, HS_STOP, HS_BYTE} ipra_hstate_t;
endpackage

// File: rtl/ipra_if.sv
// Two-wire bus carrier: resolves the wired-AND levels from each end's enables
`timescale 1ns/1ps
`default_nettype none
interface ipra_if;
    logic scl_o_h;
    logic scl_oe_h;
    logic sda_o_h;
    logic sda_oe_h;
    logic sda_o_d;
    logic sda_oe_d;
    logic scl;
    logic sda;
    // Pulled up; any enabled driver pulling low wins, otherwise the line reads high
    assign scl = !(scl_oe_h && !scl_o_h);
    assign sda = !((sda_oe_h && !sda_o_h) || (sda_oe_d && !sda_o_d));
    modport device (input scl, input sda, output sda_o_d, output sda_oe_d);
    modport host (input scl, input sda, output scl_o_h, output scl_oe_h,
                  output sda_o_h, output sda_oe_h);
endinterface
`default_nettype wire

// File: rtl/ipra_sync.sv
// Two-flop synchroniser with edge detection for one bus line
`timescale 1ns/1ps
`default_nettype none
`include "ipra_regs.svh"
module ipra_sync (
    input  wire logic pclk,     // System clock
    input  wire logic presetn,  // Asynchronous reset, active low
    input  wire logic din,      // Line level from outside the clock domain
    output logic      lvl,      // Synchronised level
    output logic      rise,     // One-cycle pulse on a rising edge
    output logic      fall      // One-cycle pulse on a falling edge
);
    logic [2:0] sh_q;
    logic [2:0] sh_d;

    always_comb begin
        sh_d = {sh_q[1:0], din};
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh_q <= `IPRA_SYNC_IDLE;
        end else begin
            sh_q <= sh_d;
        end
    end

    assign lvl  = sh_q[1];
    assign rise = sh_q[1] & ~sh_q[2];
    assign fall = ~sh_q[1] & sh_q[2];
endmodule
`default_nettype wire

// File: rtl/ipra_device.sv
// I2C slave end: paged bank of 8-bit control registers behind the two-wire port
// Functional notes
// - 8-bit registers, 128 per page
// - register 0 of every page selects page
// - page 0 after reset and soft reset
// - coefficient storage only in pages 2-4
// - slave only, all standard bus speeds
// - default slave address 1001110
// - broadcast enable switches address to 1001100
// - bytes MSB first, acknowledged by receiver
// - start and stop only while SCL high
// - acknowledge pulls SDA low, otherwise release
// - no limit on bytes per transaction
// - write: address, register, data, each acknowledged
// - write data lands at successive addresses
// - read: register write, repeated start, read
// - read continues while master acknowledges
// - master NACKs final read byte, then stops
// - master writes register 0 to change page
// - master avoids reserved pages and registers
// - soft reset restores defaults, bit self-clears
`timescale 1ns/1ps
`default_nettype none
`include "ipra_regs.svh"
module ipra_device #(
    parameter int PAGE_REGS  = 128,  // Registers per page
    parameter int COEF_PAGES = 3     // Pages holding coefficients
) (
    input  wire logic pclk,              // System clock
    input  wire logic presetn,           // Asynchronous reset, active low
    ipra_if.device    bus,               // Two-wire control bus
    input  wire logic [6:0] cfg_addr,    // Page 0 register to show on cfg_data
    output logic [7:0]      cfg_data,    // Contents of page 0 register cfg_addr
    output logic [7:0]      cur_page,    // Currently selected page
    output logic            bcast_en,    // Broadcast address in use
    output logic            soft_reset   // One-cycle pulse after a soft reset
);
    localparam int PW   = $clog2(PAGE_REGS);
    localparam int BW   = $clog2(COEF_PAGES + 1);
    localparam int NREG = (COEF_PAGES + 1) * PAGE_REGS;

    if (PAGE_REGS != 128) begin : g_chk_regs
        $error("PAGE_REGS must be 128");
    end
    if (COEF_PAGES != int'(`IPRA_COEF_LAST - `IPRA_COEF_FIRST) + 1) begin : g_chk_coef
        $error("COEF_PAGES must match the coefficient page range");
    end

    ipra_pkg::ipra_dstate_t st_q;
    ipra_pkg::ipra_dstate_t st_d;
    ipra_pkg::ipra_byte_t   kind_q;
    ipra_pkg::ipra_byte_t   kind_d;
    logic [3:0]    cnt_q;
    logic [3:0]    cnt_d;
    logic [7:0]    sr_q;
    logic [7:0]    sr_d;
    logic [PW-1:0] ptr_q;
    logic [PW-1:0] ptr_d;
    logic [PW-1:0] rd_ptr;
    logic [7:0]    page_q;
    logic [7:0]    page_d;
    logic          rw_q;
    logic          rw_d;
    logic          nack_q;
    logic          nack_d;
    logic          oe_q;
    logic          oe_d;
    logic          clr;
    logic          clr_q;
    logic          we;
    logic [7:0]    rdata;
    logic [7:0]    cfg_q;
    logic          page_ok;
    logic [BW-1:0] bank;
    logic [6:0]    my_addr;
    logic [7:0]    mem_q [0:NREG-1];
    logic [7:0]    mem_d [0:NREG-1];
    logic          scl_s;
    logic          scl_rise;
    logic          scl_fall;
    logic          sda_s;
    logic          sda_rise;
    logic          sda_fall;
    logic          start_c;
    logic          stop_c;

    ipra_sync u_scl (.pclk(pclk), .presetn(presetn), .din(bus.scl),
                     .lvl(scl_s), .rise(scl_rise), .fall(scl_fall));
    ipra_sync u_sda (.pclk(pclk), .presetn(presetn), .din(bus.sda),
                     .lvl(sda_s), .rise(sda_rise), .fall(sda_fall));

    assign start_c = sda_fall && scl_s;
    assign stop_c  = sda_rise && scl_s;
    assign bcast_en = mem_q[`IPRA_REG_SLEEP][`IPRA_BIT_BCAST];
    assign my_addr  = bcast_en ? `IPRA_ADDR_BCAST : `IPRA_ADDR_MAIN;

    // Bank 0 is page 0, banks 1.. are the coefficient pages; other pages hold nothing
    always_comb begin
        page_ok = (page_q == `IPRA_PAGE_CFG) ||
                  (page_q >= `IPRA_COEF_FIRST && page_q <= `IPRA_COEF_LAST);
        bank    = (page_q == `IPRA_PAGE_CFG) ? BW'(0) : BW'(page_q - `IPRA_BANK_OFS);
        rd_ptr  = (st_q == ipra_pkg::DS_MACK) ? PW'(ptr_q + PW'(1)) : ptr_q;
        if (rd_ptr == PW'(`IPRA_REG_PAGE)) begin
            rdata = page_q;
        end else if (page_ok) begin
            rdata = mem_q[{bank, rd_ptr}];
        end else begin
            rdata = `IPRA_MEM_DEF;
        end
    end

    // Protocol engine: acts on synchronised SCL edges, bytes of any count
    always_comb begin
        st_d   = st_q;
        kind_d = kind_q;
        cnt_d  = cnt_q;
        sr_d   = sr_q;
        ptr_d  = ptr_q;
        page_d = page_q;
        rw_d   = rw_q;
        nack_d = nack_q;
        oe_d   = oe_q;
        we     = 1'b0;
        clr    = 1'b0;
        if (start_c) begin
            st_d   = ipra_pkg::DS_RX;
            kind_d = ipra_pkg::BY_ADDR;
            cnt_d  = 4'h0;
            oe_d   = 1'b0;
        end else if (stop_c) begin
            st_d = ipra_pkg::DS_IDLE;
            oe_d = 1'b0;
        end else begin
            case (st_q)
                ipra_pkg::DS_RX: begin
                    if (scl_rise && cnt_q != `IPRA_BYTE_BITS) begin
                        sr_d  = {sr_q[6:0], sda_s};
                        cnt_d = 4'(cnt_q + 4'h1);
                    end else if (scl_fall && cnt_q == `IPRA_BYTE_BITS) begin
                        cnt_d = 4'h0;
                        st_d  = ipra_pkg::DS_ACK;
                        oe_d  = 1'b1;
                        case (kind_q)
                            ipra_pkg::BY_ADDR: begin
                                if (sr_q[7:1] == my_addr) begin
                                    rw_d   = sr_q[0];
                                    kind_d = sr_q[0] ? ipra_pkg::BY_DATA : ipra_pkg::BY_REG;
                                end else begin
                                    st_d = ipra_pkg::DS_IDLE;
                                    oe_d = 1'b0;
                                end
                            end
                            ipra_pkg::BY_REG: begin
                                ptr_d  = sr_q[PW-1:0];
                                kind_d = ipra_pkg::BY_DATA;
                            end
                            default: begin
                                ptr_d = PW'(ptr_q + PW'(1));
                                if (ptr_q == PW'(`IPRA_REG_PAGE)) begin
                                    page_d = sr_q;
                                end else if (page_q == `IPRA_PAGE_CFG &&
                                             ptr_q == PW'(`IPRA_REG_SWRST)) begin
                                    clr    = sr_q[`IPRA_BIT_SWRST];
                                    page_d = clr ? `IPRA_PAGE_DEF : page_q;
                                end else begin
                                    we = page_ok;
                                end
                            end
                        endcase
                    end
                end
                ipra_pkg::DS_ACK: begin
                    if (scl_fall) begin
                        cnt_d = 4'h0;
                        if (rw_q) begin
                            st_d = ipra_pkg::DS_TX;
                            sr_d = rdata;
                            oe_d = !rdata[7];
                        end else begin
                            st_d = ipra_pkg::DS_RX;
                            oe_d = 1'b0;
                        end
                    end
                end
                ipra_pkg::DS_TX: begin
                    if (scl_fall) begin
                        if (cnt_q == `IPRA_LAST_BIT) begin
                            st_d = ipra_pkg::DS_MACK;
                            oe_d = 1'b0;
                        end else begin
                            sr_d  = {sr_q[6:0], 1'b0};
                            oe_d  = !sr_q[6];
                            cnt_d = 4'(cnt_q + 4'h1);
                        end
                    end
                end
                ipra_pkg::DS_MACK: begin
                    if (scl_rise) begin
                        nack_d = sda_s;
                    end else if (scl_fall) begin
                        cnt_d = 4'h0;
                        if (!nack_q) begin
                            st_d  = ipra_pkg::DS_TX;
                            ptr_d = rd_ptr;
                            sr_d  = rdata;
                            oe_d  = !rdata[7];
                        end else begin
                            st_d = ipra_pkg::DS_IDLE;
                        end
                    end
                end
                default: begin
                    oe_d = 1'b0;
                end
            endcase
        end
    end

    // Register bank next state; soft reset clears every stored byte
    always_comb begin
        mem_d = mem_q;
        if (clr) begin
            for (int i = 0; i < NREG; i++) begin
                mem_d[i] = `IPRA_MEM_DEF;
            end
        end else if (we) begin
            mem_d[{bank, ptr_q}] = sr_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q   <= ipra_pkg::DS_IDLE;
            kind_q <= ipra_pkg::BY_ADDR;
            cnt_q  <= 4'h0;
            sr_q   <= 8'h00;
            ptr_q  <= '0;
            page_q <= `IPRA_PAGE_DEF;
            rw_q   <= 1'b0;
            nack_q <= 1'b1;
            oe_q   <= 1'b0;
            clr_q  <= 1'b0;
            cfg_q  <= 8'h00;
            for (int i = 0; i < NREG; i++) begin
                mem_q[i] <= `IPRA_MEM_DEF;
            end
        end else begin
            st_q   <= st_d;
            kind_q <= kind_d;
            cnt_q  <= cnt_d;
            sr_q   <= sr_d;
            ptr_q  <= ptr_d;
            page_q <= page_d;
            rw_q   <= rw_d;
            nack_q <= nack_d;
            oe_q   <= oe_d;
            clr_q  <= clr;
            cfg_q  <= mem_q[{{BW{1'b0}}, cfg_addr[PW-1:0]}];
            mem_q  <= mem_d;
        end
    end

    assign bus.sda_o_d  = 1'b0;
    assign bus.sda_oe_d = oe_q;
    assign cfg_data     = cfg_q;
    assign cur_page     = page_q;
    assign soft_reset   = clr_q;
endmodule
`default_nettype wire

// File: rtl/ipra_host.sv
// I2C master end: APB-programmed byte engine that generates SCL from pclk
`timescale 1ns/1ps
`default_nettype none
`include "ipra_regs.svh"
module ipra_host (
    input  wire logic        pclk,     // System clock
    input  wire logic        presetn,  // Asynchronous reset, active low
    input  wire logic        psel,     // APB select
    input  wire logic        penable,  // APB access phase
    input  wire logic        pwrite,   // APB write
    input  wire logic [11:0] paddr,    // APB byte address
    input  wire logic [31:0] pwdata,   // APB write data
    output logic [31:0]      prdata,   // APB read data
    output logic             pready,   // APB ready
    output logic             pslverr,  // APB error on unmapped address
    ipra_if.host             bus       // Two-wire control bus
);
    ipra_pkg::ipra_hstate_t st_q;
    ipra_pkg::ipra_hstate_t st_d;
    logic [1:0]  ph_q;
    logic [1:0]  ph_d;
    logic [3:0]  bit_q;
    logic [3:0]  bit_d;
    logic [15:0] tick_q;
    logic [15:0] tick_d;
    logic [15:0] div_q;
    logic [15:0] div_d;
    logic [7:0]  sh_q;
    logic [7:0]  sh_d;
    logic        rd_q;
    logic        rd_d;
    logic        ackme_q;
    logic        ackme_d;
    logic        nack_q;
    logic        nack_d;
    logic        scl_oe_q;
    logic        scl_oe_d;
    logic        sda_oe_q;
    logic        sda_oe_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic        scl_s;
    logic        sda_s;
    logic        tick_end;
    logic        adv;
    logic        mapped;
    logic        wr_acc;
    logic [2:0]  op;

    ipra_sync u_scl (.pclk(pclk), .presetn(presetn), .din(bus.scl),
                     .lvl(scl_s), .rise(), .fall());
    ipra_sync u_sda (.pclk(pclk), .presetn(presetn), .din(bus.sda),
                     .lvl(sda_s), .rise(), .fall());

    // Whether to pull SDA low for bit b: data bits when writing, ack bit when reading
    function automatic logic drive(input logic [3:0] b, input logic [7:0] s,
                                   input logic rd, input logic am);
        drive = (b == `IPRA_BYTE_BITS) ? (rd && am) : (!rd && !s[7]);
    endfunction

    assign mapped   = (paddr == `IPRA_APB_CTRL) || (paddr == `IPRA_APB_STAT) ||
                      (paddr == `IPRA_APB_DIV);
    assign wr_acc   = psel && penable && pwrite;
    assign op       = pwdata[`IPRA_F_OP];
    assign tick_end = tick_q >= 16'(div_q - 16'h0001);
    // Phase RISE waits for SCL to read high before it ends
    assign adv      = tick_end && !(ph_q == `IPRA_PH_RISE && !scl_s);

    always_comb begin
        st_d     = st_q;
        ph_d     = ph_q;
        bit_d    = bit_q;
        tick_d   = tick_q;
        div_d    = div_q;
        sh_d     = sh_q;
        rd_d     = rd_q;
        ackme_d  = ackme_q;
        nack_d   = nack_q;
        scl_oe_d = scl_oe_q;
        sda_oe_d = sda_oe_q;
        prdata_d = prdata_q;
        if (psel && !penable) begin
            prdata_d = 32'h0000_0000;
            if (paddr == `IPRA_APB_STAT) begin
                prdata_d[`IPRA_F_BUSY] = st_q != ipra_pkg::HS_IDLE;
                prdata_d[`IPRA_F_NACK] = nack_q;
                prdata_d[`IPRA_F_DATA] = sh_q;
            end else if (paddr == `IPRA_APB_DIV) begin
                prdata_d[`IPRA_F_DIV] = div_q;
            end
        end
        if (wr_acc && paddr == `IPRA_APB_DIV) begin
            div_d = (pwdata[`IPRA_F_DIV] < `IPRA_DIV_MIN) ? `IPRA_DIV_MIN : pwdata[`IPRA_F_DIV];
        end
        case (st_q)
            ipra_pkg::HS_IDLE: begin
                // Page moves and register accesses are sequenced by software
                if (wr_acc && paddr == `IPRA_APB_CTRL) begin
                    tick_d = 16'h0000;
                    ph_d   = `IPRA_PH_DRIVE;
                    bit_d  = 4'h0;
                    case (op)
                        `IPRA_OP_START: begin
                            st_d     = ipra_pkg::HS_START;
                            sda_oe_d = 1'b0;
                        end
                        `IPRA_OP_STOP: begin
                            st_d     = ipra_pkg::HS_STOP;
                            sda_oe_d = 1'b1;
                        end
                        `IPRA_OP_WRITE, `IPRA_OP_RD_ACK, `IPRA_OP_RD_NACK: begin
                            st_d     = ipra_pkg::HS_BYTE;
                            rd_d     = op != `IPRA_OP_WRITE;
                            ackme_d  = op == `IPRA_OP_RD_ACK;
                            sh_d     = pwdata[`IPRA_F_DATA];
                            sda_oe_d = drive(4'h0, pwdata[`IPRA_F_DATA],
                                             op != `IPRA_OP_WRITE, op == `IPRA_OP_RD_ACK);
                        end
                        default: begin
                            st_d = ipra_pkg::HS_IDLE;
                        end
                    endcase
                end
            end
            default: begin
                if (adv) begin
                    tick_d = 16'h0000;
                    ph_d   = 2'(ph_q + 2'h1);
                    case (ph_q)
                        `IPRA_PH_DRIVE: begin
                            scl_oe_d = 1'b0;
                        end
                        `IPRA_PH_RISE: begin
                            if (st_q == ipra_pkg::HS_START) begin
                                sda_oe_d = 1'b1;
                            end else if (st_q == ipra_pkg::HS_STOP) begin
                                sda_oe_d = 1'b0;
                            end else if (bit_q != `IPRA_BYTE_BITS) begin
                                sh_d = {sh_q[6:0], sda_s};
                            end else begin
                                nack_d = sda_s;
                            end
                        end
                        `IPRA_PH_SAMPLE: begin
                            scl_oe_d = st_q != ipra_pkg::HS_STOP;
                        end
                        default: begin
                            if (st_q != ipra_pkg::HS_BYTE || bit_q == `IPRA_BYTE_BITS) begin
                                st_d = ipra_pkg::HS_IDLE;
                            end else begin
                                bit_d    = 4'(bit_q + 4'h1);
                                sda_oe_d = drive(4'(bit_q + 4'h1), sh_q, rd_q, ackme_q);
                            end
                        end
                    endcase
                end else if (!tick_end) begin
                    tick_d = 16'(tick_q + 16'h0001);
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q     <= ipra_pkg::HS_IDLE;
            ph_q     <= `IPRA_PH_DRIVE;
            bit_q    <= 4'h0;
            tick_q   <= 16'h0000;
            div_q    <= `IPRA_DIV_RST;
            sh_q     <= 8'h00;
            rd_q     <= 1'b0;
            ackme_q  <= 1'b0;
            nack_q   <= 1'b0;
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            st_q     <= st_d;
            ph_q     <= ph_d;
            bit_q    <= bit_d;
            tick_q   <= tick_d;
            div_q    <= div_d;
            sh_q     <= sh_d;
            rd_q     <= rd_d;
            ackme_q  <= ackme_d;
            nack_q   <= nack_d;
            scl_oe_q <= scl_oe_d;
            sda_oe_q <= sda_oe_d;
            prdata_q <= prdata_d;
        end
    end

    assign prdata       = prdata_q;
    assign pready       = 1'b1;
    assign pslverr      = psel && penable && !mapped;
    assign bus.scl_o_h  = 1'b0;
    assign bus.scl_oe_h = scl_oe_q;
    assign bus.sda_o_h  = 1'b0;
    assign bus.sda_oe_h = sda_oe_q;
endmodule
`default_nettype wire

// File: verification/ipra_chk.sv
// Concurrent checks on the two-wire bus between the two ends
`timescale 1ns/1ps
`default_nettype none
module ipra_chk (
    input wire logic pclk,     // Clock
    input wire logic presetn,  // Reset, low
    input wire logic scl,      // Clock line
    input wire logic sda,      // Data line
    input wire logic sda_oe_d  // Device pulls data
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sda_hold_a: assert property (scl && $past(scl) |-> $stable(sda_oe_d))
        else $error("sda moved");
    ack_rise_a: assert property ($rose(sda_oe_d) |-> !scl [*3])
        else $error("late ack");
    ack_fall_a: assert property ($fell(sda_oe_d) |-> !scl)
        else $error("early release");
    ack_whole_a: assert property ($rose(scl) && sda_oe_d |-> sda_oe_d [*6])
        else $error("short ack");
    start_free_a: assert property (scl && $fell(sda) |-> !sda_oe_d)
        else $error("start by device");
    addr_free_a: assert property (scl && $fell(sda) |=> !sda_oe_d [*8])
        else $error("drive at address");
    stop_free_a: assert property (scl && $rose(sda) |=> !sda_oe_d [*8])
        else $error("drive after stop");
    scl_high_a: assert property ($rose(scl) |-> scl [*6])
        else $error("short clock high");
endmodule
`default_nettype wire

// File: verification/tb_i2c_paged_register_access.sv
// Bench joining the host and device ends of the paged I2C port
`timescale 1ns/1ps
`default_nettype none
module tb_i2c_paged_register_access;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, bcast_en, soft_reset, err;
    logic [31:0] pwdata, prdata, rd, st;
    logic [11:0] paddr;
    logic [7:0]  cfg_data, cur_page, got;
    logic [6:0]  cfg_addr;
    logic [2:0]  o;
    int          mismatches = 0, checks_done = 0, cyc = 0, sr_seen = 0;
    // Op, byte, expected nack or data; op 6 adds a start, op bit 3 a stop
    localparam logic [19:0] ROWS [38] = '{20'h69C00,20'h30200,20'hB0400,20'hE9C01,
        20'h69800,20'h37F00,20'h32200,20'h30300,20'hBA500,20'h69800,20'h30100,20'h69900,
        20'hD00A5,20'h69800,20'h30000,20'h30100,20'hB7700,20'h69800,20'h30000,20'h69900,
        20'h40001,20'hD0000,20'h69800,20'h30000,20'hB0000,20'h69800,20'h37F00,20'h69900,
        20'h40022,20'hD0000,20'h69800,20'h30100,20'hB0100,20'hEA001,20'h69C00,20'h30200,
        20'h69D00,20'hD0000};
    ipra_if bus_if ();
    ipra_host u_ipra_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bus(bus_if));
    ipra_device u_ipra_device (.pclk(pclk), .presetn(presetn), .bus(bus_if),
        .cfg_addr(cfg_addr), .cfg_data(cfg_data), .cur_page(cur_page), .bcast_en(bcast_en),
        .soft_reset(soft_reset));
    ipra_chk u_ipra_chk (.pclk, .presetn, .scl(bus_if.scl), .sda(bus_if.sda),
        .sda_oe_d(bus_if.sda_oe_d));
    initial forever #10 pclk = ~pclk;
    always @(posedge pclk) if (cyc++ == 60000) final_report(1);
    always @(posedge pclk) if (soft_reset === 1'b1) sr_seen++;
    task chk(input string nm, input logic [7:0] e, input logic [7:0] s);
        checks_done++;
        if (s !== e) $display("MISMATCH %s exp %h got %h", nm, e, s);
        if (s !== e) mismatches++;
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, wd};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task op(input logic [2:0] c, input logic [7:0] b);
        apb(1'b1, 12'h000, {16'h0000, b, 5'h00, c});
        do apb(1'b0, 12'h004, 32'h0); while (rd[0] !== 1'b0);
        st = rd;
    endtask
    task final_report(input int to);
        mismatches += to;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        cfg_addr = 7'h7F;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        chk("page", 8'h00, cur_page);
        $display("reset test done");
        foreach (ROWS[i]) begin
            o = ROWS[i][18:16];
            if (o == 3'h6) op(3'h1, 8'h00);
            op((o == 3'h6) ? 3'h3 : o, ROWS[i][15:8]);
            got = (o[2] && !o[1]) ? st[15:8] : {7'h00, st[1]};
            chk("row", ROWS[i][7:0], got);
            if (ROWS[i][19]) op(3'h2, 8'h00);
            if (i == 2) chk("bcast", 8'h01, {7'h00, bcast_en});
            if (i == 15) chk("page1", 8'h01, cur_page);
            if (i == 24) chk("cfg", 8'h22, cfg_data);
        end
        $display("row tests done");
        chk("sw page", 8'h00, cur_page);
        chk("sw bcast", 8'h00, {7'h00, bcast_en});
        chk("sw cfg", 8'h00, cfg_data);
        chk("sw pulse", 8'h01, 8'(sr_seen));
        apb(1'b0, 12'h100, 32'h0);
        chk("slverr", 8'h01, {7'h00, err});
        chk("unmapped", 8'h00, rd[7:0]);
        apb(1'b1, 12'h008, 32'h1);
        apb(1'b0, 12'h008, 32'h0);
        chk("div", 8'h04, rd[7:0]);
        op(3'h1, 8'h00);
        op(3'h3, 8'h9C);
        chk("fast", 8'h00, {7'h00, st[1]});
        op(3'h2, 8'h00);
        $display("awkward tests done");
        final_report(0);
    end
endmodule
`default_nettype wire
